// File: shared/drs_defines.vh
// constants for the drive run/status logic
`ifndef DRS_DEFINES_VH
`define DRS_DEFINES_VH
// ==========================================
// register offsets (byte addresses)
`define DRS_REG_CTRL 8'h00
`define DRS_REG_CMD 8'h04
`define DRS_REG_STATUS 8'h08
`define DRS_REG_FAULT 8'h0C
`define DRS_REG_DELAY 8'h10
// ==========================================
// control register fields
`define DRS_CTRL_HAND 0
`define DRS_CTRL_LOCALREF 1
`define DRS_CTRL_AUTORAMP 2
`define DRS_CTRL_CLOSEDLOOP 3
`define DRS_CTRL_BOOST 4
`define DRS_CTRL_SLEEP 5
`define DRS_CTRL_SCHED_WAIT 6
`define DRS_CTRL_FB_PROFILE 7
`define DRS_CTRL_AUTORESET 8
`define DRS_CTRL_WARN_FIRST 9
`define DRS_CTRL_RESET 16'h0040
// ==========================================
// command register bits (write one to act)
`define DRS_CMD_START 0
`define DRS_CMD_STOP 1
`define DRS_CMD_RESET 2
`define DRS_CMD_COAST 3
`define DRS_CMD_JOG 4
`define DRS_CMD_FREEZE 5
`define DRS_CMD_AMA_DONE 6
// ==========================================
// status codes
`define DRS_ST_NOT_READY 5'h00
`define DRS_ST_TRIP 5'h01
`define DRS_ST_TRIP_LOCK 5'h02
`define DRS_ST_START_INH 5'h03
`define DRS_ST_UNREADY 5'h04
`define DRS_ST_ADAPT_DONE 5'h05
`define DRS_ST_OFF 5'h06
`define DRS_ST_STOP 5'h07
`define DRS_ST_START_FR 5'h08
`define DRS_ST_RUN_REQ 5'h09
`define DRS_ST_JOG_REQ 5'h0A
`define DRS_ST_HOLD_AWAITING_PERMISSIVE 5'h0B
`define DRS_ST_START_DEL 5'h0C
`define DRS_ST_SLEEP 5'h0D
`define DRS_ST_BOOST 5'h0E
`define DRS_ST_AUTO_RAMP 5'h0F
`define DRS_ST_RAMPING 5'h10
`define DRS_ST_JOG 5'h11
`define DRS_ST_FRZ_OUT 5'h12
`define DRS_ST_RUNNING 5'h13
`define DRS_ST_STANDBY 5'h14
// ==========================================
// status line fields
`define DRS_CTL_AUTO 2'h0
`define DRS_CTL_HAND 2'h1
`define DRS_CTL_OFF 2'h2
`define DRS_REF_LOCAL 1'b0
`define DRS_REF_REMOTE 1'b1
`define DRS_LINE_NUMBER 3'h4
`define DRS_EVT_SCHED_NOT_READY 8'h51
`define DRS_REF_ZERO 16'h0000
`define DRS_REF_STEP 16'h0001
`define DRS_DELAY_ZERO 16'h0000
`endif

// File: src/drs_sync_flag.v
// sticky flag where a set wins over a clear
`timescale 1ns/100ps
module drs_sync_flag (
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // control
   input wire set,
   input wire clr,
   // state
   output reg flag
);
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clr) begin
         flag <= 1'b0;
      end
   end
endmodule // drs_sync_flag

// File: src/drs_status_enc.v
// status priority encoder
`timescale 1ns/100ps
`include "drs_defines.vh"
module drs_status_enc (
   // conditions
   input wire trip_lock,
   input wire trip,
   input wire not_ready,
   input wire start_inh,
   input wire unready,
   input wire adapt_done,
   input wire off_state,
   input wire stopped,
   input wire start_fr,
   input wire run_req,
   input wire jog_req,
   input wire hold_awaiting_permissive,
   input wire start_del,
   input wire sleeping,
   input wire boost,
   input wire auto_ramp,
   input wire ramping,
   input wire jogging,
   input wire frozen,
   input wire running,
   // result
   output reg [4:0] code
);
   // first match wins; faults rank above everything else
   always @* begin
      if (trip_lock) code = `DRS_ST_TRIP_LOCK;
      else if (trip) code = `DRS_ST_TRIP;
      else if (start_inh) code = `DRS_ST_START_INH;
      else if (not_ready) code = `DRS_ST_NOT_READY;
      else if (adapt_done) code = `DRS_ST_ADAPT_DONE;
      else if (unready) code = `DRS_ST_UNREADY;
      else if (off_state) code = `DRS_ST_OFF;
      else if (start_fr) code = `DRS_ST_START_FR;
      else if (run_req) code = `DRS_ST_RUN_REQ;
      else if (jog_req) code = `DRS_ST_JOG_REQ;
      else if (hold_awaiting_permissive) code = `DRS_ST_HOLD_AWAITING_PERMISSIVE;
      else if (start_del) code = `DRS_ST_START_DEL;
      else if (sleeping) code = `DRS_ST_SLEEP;
      else if (boost) code = `DRS_ST_BOOST;
      else if (auto_ramp) code = `DRS_ST_AUTO_RAMP;
      else if (ramping) code = `DRS_ST_RAMPING;
      else if (jogging) code = `DRS_ST_JOG;
      else if (frozen) code = `DRS_ST_FRZ_OUT;
      else if (running) code = `DRS_ST_RUNNING;
      else if (stopped) code = `DRS_ST_STOP;
      else code = `DRS_ST_STANDBY;
   end
endmodule // drs_status_enc

// File: src/drs_run_status.v
// drive run-state and status reporting
// Behaviour
// - scheduler start-up: 0 catch up, 1 wait
// - status line: control, reference, run status
// - terminal mode takes terminals and link; panel keys
// - off on stop key or both starts low
// - panel reference by keys, else remote
// - auto ramp raises frequency, reports status
// - sleep boost only in closed loop
// - sleep stops motor, restarts on demand
// - start delay reported, then ramp up
// - requests wait for run permissive
// - reverse-start plus start together hold stopped
// - adaptation done held until reset
// - standby when nothing blocks a start
// - unready when coast inhibit low or coast
// - not ready on trip or any off low
// - start inhibited only with profile option
// - trip lock clears after power cycle, reset
// - trip reset by key, input, link, auto
// - alarm at once, or warning first if configured
// - trip coasts, flashes, clears after reset
// - stop status after any stop source
// - event 81 when scheduler not ready
`timescale 1ns/100ps
`include "drs_defines.vh"
module drs_run_status (
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // register port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   // panel keys
   input wire key_start,
   input wire key_stop,
   input wire key_reset,
   input wire key_up,
   input wire key_down,
   // terminals
   input wire term_start,
   input wire term_rev_start,
   input wire term_stop,
   input wire term_reset,
   input wire term_jog,
   input wire term_freeze,
   input wire term_permissive,
   input wire coast_inhibited_n,
   input wire off_condition_one,
   input wire off_condition_two,
   input wire off_condition_three,
   input wire [15:0] term_ref,
   // serial link and plant
   input wire [15:0] link_ref,
   input wire link_ref_valid,
   input wire fault_alarm,
   input wire fault_warning,
   input wire fault_lockable,
   input wire fault_present,
   input wire power_restored,
   input wire dc_overvolt,
   input wire at_reference,
   input wire demand_low,
   input wire sched_ready,
   input wire sched_on_due,
   input wire sched_on_missed,
   input wire auto_reset_req,
   // outputs
   output reg motor_run,
   output reg motor_coast,
   output reg raise_freq,
   output reg [15:0] ref_out,
   output reg [1:0] line_control,
   output reg line_ref,
   output reg [4:0] line_status,
   output reg [2:0] line_number,
   output reg alarm_flash,
   output reg warning_flash,
   output reg [7:0] event_code,
   output reg event_valid,
   output reg sched_start
);
   // ==========================================
   // registers
   reg [15:0] ctrl;
   reg [15:0] delay_set;
   reg [15:0] delay_cnt;
   reg [6:0] cmd_pulse;
   reg run_cmd;
   reg jog_cmd;
   reg frz_cmd;
   reg stop_seen;
   reg sched_armed;
   reg sched_prev_rdy;
   reg lock_power_seen;
   wire trip_flag;
   wire lock_flag;
   wire adapt_flag;
   wire coast_flag;
   wire [4:0] next_status;
   wire hand = ctrl[`DRS_CTRL_HAND];
   wire cmd_wr = wr && (addr == `DRS_REG_CMD);
   // ==========================================
   // register writes and command strobes
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= `DRS_CTRL_RESET;
         delay_set <= `DRS_DELAY_ZERO;
         cmd_pulse <= 7'h00;
      end else begin
         cmd_pulse <= cmd_wr ? wdata[6:0] : 7'h00;
         if (wr && addr == `DRS_REG_CTRL) ctrl <= wdata[15:0];
         if (wr && addr == `DRS_REG_DELAY) delay_set <= wdata[15:0];
      end
   end
   // ==========================================
   // command sources by control mode
   wire link_ok = !hand;
   wire src_start = hand ? key_start
                         : (term_start || (link_ok && cmd_pulse[`DRS_CMD_START]));
   wire src_stop = key_stop || (!hand && (term_stop || cmd_pulse[`DRS_CMD_STOP]));
   wire start_low = !key_start && !term_start;
   wire off_state = key_stop || start_low;
   wire src_jog = !hand && (term_jog || cmd_pulse[`DRS_CMD_JOG]);
   wire src_frz = !hand && (term_freeze || cmd_pulse[`DRS_CMD_FREEZE]);
   wire start_fr = term_rev_start && term_start && !hand;
   wire any_reset = key_reset || term_reset || cmd_pulse[`DRS_CMD_RESET]
                    || (ctrl[`DRS_CTRL_AUTORESET] && auto_reset_req);
   // ==========================================
   // trip handling
   // a lock needs a supply cycle before the next reset counts
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) lock_power_seen <= 1'b0;
      else if (!lock_flag) lock_power_seen <= 1'b0;
      else if (power_restored && !fault_present) lock_power_seen <= 1'b1;
   end
   wire trip_set = fault_alarm && !fault_lockable;
   wire lock_set = fault_alarm && fault_lockable;
   drs_sync_flag u_trip (
      .core_clk(core_clk),
      .rstn(rstn),
      .set(trip_set),
      .clr(any_reset && !fault_present),
      .flag(trip_flag)
   );
   drs_sync_flag u_lock (
      .core_clk(core_clk),
      .rstn(rstn),
      .set(lock_set),
      .clr(any_reset && lock_power_seen),
      .flag(lock_flag)
   );
   drs_sync_flag u_adapt (
      .core_clk(core_clk),
      .rstn(rstn),
      .set(cmd_pulse[`DRS_CMD_AMA_DONE]),
      .clr(any_reset),
      .flag(adapt_flag)
   );
   drs_sync_flag u_coast (
      .core_clk(core_clk),
      .rstn(rstn),
      .set(link_ok && cmd_pulse[`DRS_CMD_COAST]),
      .clr(any_reset),
      .flag(coast_flag)
   );
   wire tripped = trip_flag || lock_flag;
   wire offs_low = !off_condition_one || !off_condition_two || !off_condition_three;
   wire not_ready = tripped || offs_low;
   wire start_inh = ctrl[`DRS_CTRL_FB_PROFILE]
                    && (!off_condition_two || !off_condition_three);
   wire unready = !coast_inhibited_n || coast_flag;
   wire blocked = not_ready || adapt_flag || unready;
   // ==========================================
   // run state
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         run_cmd <= 1'b0;
         jog_cmd <= 1'b0;
         frz_cmd <= 1'b0;
         stop_seen <= 1'b0;
         delay_cnt <= `DRS_DELAY_ZERO;
      end else begin
         if (src_stop || off_state || blocked) begin
            run_cmd <= 1'b0;
            stop_seen <= src_stop || stop_seen;
         end else if ((src_start || sched_start) && !run_cmd) begin
            // starts are held levels; only the first loads, so the delay can expire
            delay_cnt <= delay_set;
            run_cmd <= 1'b1;
            stop_seen <= 1'b0;
         end else if (delay_cnt != `DRS_DELAY_ZERO && term_permissive) begin
            delay_cnt <= delay_cnt - `DRS_REF_STEP;
         end
         jog_cmd <= src_jog && !blocked;
         frz_cmd <= src_frz && !blocked;
      end
   end
   wire delaying = run_cmd && delay_cnt != `DRS_DELAY_ZERO;
   wire waiting = !term_permissive;
   wire boost_ok = ctrl[`DRS_CTRL_BOOST] && ctrl[`DRS_CTRL_CLOSEDLOOP];
   wire sleeping = ctrl[`DRS_CTRL_SLEEP] && demand_low && run_cmd;
   wire auto_ramp = ctrl[`DRS_CTRL_AUTORAMP] && dc_overvolt && run_cmd;
   wire motor_go = (run_cmd || jog_cmd) && !waiting && !delaying && !sleeping
                   && !start_fr && !blocked;
   // ==========================================
   // reference select
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ref_out <= `DRS_REF_ZERO;
      end else if (frz_cmd && !waiting) begin
         ref_out <= ref_out;
      end else if (ctrl[`DRS_CTRL_LOCALREF]) begin
         if (key_up && !key_down) ref_out <= ref_out + `DRS_REF_STEP;
         else if (key_down && !key_up) ref_out <= ref_out - `DRS_REF_STEP;
      end else if (link_ok && link_ref_valid) begin
         ref_out <= link_ref;
      end else begin
         ref_out <= term_ref;
      end
   end
   // ==========================================
   // scheduler start-up handling
   // each rising ready edge decides whether missed actions run
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sched_armed <= 1'b0;
         sched_prev_rdy <= 1'b0;
         sched_start <= 1'b0;
         event_valid <= 1'b0;
         event_code <= 8'h00;
      end else begin
         sched_prev_rdy <= sched_ready;
         event_valid <= !sched_ready;
         event_code <= sched_ready ? 8'h00 : `DRS_EVT_SCHED_NOT_READY;
         if (sched_ready && !sched_prev_rdy) begin
            sched_armed <= 1'b1;
            sched_start <= !ctrl[`DRS_CTRL_SCHED_WAIT] && sched_on_missed;
         end else begin
            sched_start <= sched_armed && sched_on_due;
         end
      end
   end
   // ==========================================
   // status encoding
   drs_status_enc u_enc (
      .trip_lock(lock_flag),
      .trip(trip_flag),
      .not_ready(not_ready),
      .start_inh(start_inh),
      .unready(unready),
      .adapt_done(adapt_flag),
      .off_state(off_state && !run_cmd && !stop_seen),
      .stopped(stop_seen),
      .start_fr(start_fr),
      .run_req(run_cmd && waiting),
      .jog_req(src_jog && waiting),
      .hold_awaiting_permissive(src_frz && waiting),
      .start_del(delaying),
      .sleeping(sleeping),
      .boost(boost_ok && run_cmd),
      .auto_ramp(auto_ramp),
      .ramping(motor_go && !at_reference),
      .jogging(jog_cmd && motor_go),
      .frozen(frz_cmd && motor_go),
      .running(motor_go),
      .code(next_status)
   );
   // ==========================================
   // outputs and read port
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         motor_run <= 1'b0;
         motor_coast <= 1'b1;
         raise_freq <= 1'b0;
         line_control <= `DRS_CTL_AUTO;
         line_ref <= `DRS_REF_REMOTE;
         line_status <= `DRS_ST_NOT_READY;
         line_number <= `DRS_LINE_NUMBER;
         alarm_flash <= 1'b0;
         warning_flash <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         motor_run <= motor_go;
         motor_coast <= tripped || unready;
         raise_freq <= auto_ramp;
         line_control <= off_state ? `DRS_CTL_OFF
                                   : (hand ? `DRS_CTL_HAND : `DRS_CTL_AUTO);
         line_ref <= ctrl[`DRS_CTRL_LOCALREF] ? `DRS_REF_LOCAL : `DRS_REF_REMOTE;
         line_status <= next_status;
         line_number <= `DRS_LINE_NUMBER;
         alarm_flash <= tripped || (fault_alarm && !ctrl[`DRS_CTRL_WARN_FIRST]);
         // straight to alarm unless configured to give a warning first
         warning_flash <= (tripped && fault_present)
                          || (fault_warning && ctrl[`DRS_CTRL_WARN_FIRST]);
         rdata <= 32'h0000_0000;
         if (rd) begin
            case (addr)
               `DRS_REG_CTRL: rdata <= {16'h0000, ctrl};
               `DRS_REG_STATUS: rdata <= {24'h0000_00, line_control, line_ref, next_status};
               `DRS_REG_FAULT: rdata <= {28'h000_0000, adapt_flag, coast_flag,
                                         lock_flag, trip_flag};
               `DRS_REG_DELAY: rdata <= {delay_cnt, delay_set};
               default: rdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // drs_run_status

// File: sim/drs_panel_model.sv
// panel keys and terminal levels as the far side presents them
`timescale 1ns/100ps
module drs_panel_model (
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // requests from the bench
   input wire [4:0] key_req,
   input wire [6:0] term_req,
   // levels at the block
   output logic [4:0] key_lvl,
   output logic [6:0] term_lvl
);
   // ==========================================
   // released keys and open terminals read low
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         key_lvl <= 5'h00;
         term_lvl <= 7'h00;
      end else begin
         key_lvl <= key_req;
         term_lvl <= term_req;
      end
   end
endmodule // drs_panel_model

// File: sim/drs_run_status_props.sv
// port assertions for the run/status block
`timescale 1ns/100ps
`include "drs_defines.vh"
module drs_run_status_props (
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // inputs
   input wire key_start,
   input wire key_stop,
   input wire key_up,
   input wire key_down,
   input wire term_start,
   input wire term_rev_start,
   input wire term_permissive,
   input wire coast_inhibited_n,
   input wire off_condition_one,
   input wire fault_alarm,
   input wire sched_ready,
   // outputs
   input wire motor_run,
   input wire motor_coast,
   input wire [15:0] ref_out,
   input wire [1:0] line_control,
   input wire line_ref,
   input wire [4:0] line_status,
   input wire [2:0] line_number,
   input wire alarm_flash,
   input wire [7:0] event_code,
   input wire event_valid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ==========================================
   // assertions
   chk_line_slot: assert property (line_number == `DRS_LINE_NUMBER)
      else $error("status line number wrong");
   chk_off_entry: assert property ((key_stop || (!key_start && !term_start)) [*4]
      |=> line_control == `DRS_CTL_OFF && !motor_run) else $error("off state not entered");
   chk_sched_event: assert property (!sched_ready [*2]
      |=> event_valid && event_code == `DRS_EVT_SCHED_NOT_READY) else $error("no scheduler event");
   chk_trip_coast: assert property ($rose(fault_alarm)
      |-> ##[1:3] (motor_coast && alarm_flash)) else $error("trip did not coast");
   chk_coast_hold: assert property (!coast_inhibited_n [*3] |=> !motor_run)
      else $error("motor runs while coast inhibited");
   chk_off_one: assert property (!off_condition_one [*2] |=> !motor_run && line_status inside
      {`DRS_ST_NOT_READY, `DRS_ST_TRIP, `DRS_ST_TRIP_LOCK}) else $error("not ready missed");
   chk_rev_hold: assert property ((term_start && term_rev_start
      && line_control == `DRS_CTL_AUTO) [*4] |=> !motor_run) else $error("runs with both starts");
   chk_perm_gate: assert property ($rose(motor_run) |-> $past(term_permissive)
      || $past(term_permissive, 2) || $past(term_permissive, 3)) else $error("run without permissive");
   chk_ref_hold: assert property ((line_ref == `DRS_REF_LOCAL && !key_up && !key_down) [*3]
      |=> $stable(ref_out)) else $error("local reference moved without keys");
   // ==========================================
   // main scenarios reached
   cov_run: cover property ($rose(motor_run));
   cov_lock: cover property (line_status == `DRS_ST_TRIP_LOCK);
   cov_event: cover property (event_valid);
endmodule // drs_run_status_props

bind drs_run_status drs_run_status_props drs_run_status_props_inst (.*);

// File: sim/drs_run_status_bench.sv
// self-checking bench for the run/status block
`timescale 1ns/100ps
`include "drs_defines.vh"
module drs_run_status_bench;
   // ==========================================
   // stimulus and observation
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0, rd = 1'b0;
   logic [4:0] key_req = 5'h00;
   logic [6:0] term_req = 7'h00;
   logic [4:0] key_lvl;
   logic [6:0] term_lvl;
   logic coast_inhibited_n = 1'b1, sched_ready = 1'b1, link_ref_valid = 1'b1;
   logic off_condition_one = 1'b1, off_condition_two = 1'b1, off_condition_three = 1'b1;
   logic fault_alarm = 1'b0, fault_warning = 1'b0, fault_lockable = 1'b0, fault_present = 1'b0;
   logic power_restored = 1'b0, dc_overvolt = 1'b0, at_reference = 1'b0, demand_low = 1'b0;
   logic sched_on_due = 1'b0, sched_on_missed = 1'b0, auto_reset_req = 1'b0;
   logic [15:0] term_ref = 16'h0123, link_ref = 16'h0456, r0;
   wire [31:0] rdata;
   wire [15:0] ref_out;
   wire [1:0] line_control;
   wire [4:0] line_status;
   wire [2:0] line_number;
   wire [7:0] event_code;
   wire motor_run, motor_coast, raise_freq, line_ref, alarm_flash, warning_flash;
   wire event_valid, sched_start;
   int n_errors = 0, compares = 0;
   logic [6:0] req_tab [3] = '{7'h10, 7'h20, 7'h01};
   logic [4:0] st_tab [3] = '{`DRS_ST_JOG_REQ, `DRS_ST_HOLD_AWAITING_PERMISSIVE, `DRS_ST_RUN_REQ};
   logic [2:0] off_tab [5] = '{3'b110, 3'b101, 3'b011, 3'b101, 3'b110};

   always #2 core_clk = ~core_clk;

   drs_panel_model drs_panel_model_inst (.core_clk, .rstn, .key_req, .term_req, .key_lvl,
      .term_lvl);
   drs_run_status drs_run_status_inst (.*, .key_start(key_lvl[0]), .key_stop(key_lvl[1]),
      .key_reset(key_lvl[2]), .key_up(key_lvl[3]), .key_down(key_lvl[4]),
      .term_start(term_lvl[0]), .term_rev_start(term_lvl[1]), .term_stop(term_lvl[2]),
      .term_reset(term_lvl[3]), .term_jog(term_lvl[4]), .term_freeze(term_lvl[5]),
      .term_permissive(term_lvl[6]));

   // ==========================================
   // shared tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk) wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk) rd <= 1'b0;
      #1 chk("rdata", exp, rdata);
   endtask
   task automatic wait_st(input logic [4:0] c);
      for (int i = 0; i < 40 && line_status !== c; i++) @(negedge core_clk);
      chk("line_status", 32'(c), 32'(line_status));
   endtask
   task automatic wait_run(input logic v);
      for (int i = 0; i < 40 && motor_run !== v; i++) @(negedge core_clk);
      chk("motor_run", 32'(v), 32'(motor_run));
   endtask
   task automatic clear_trip(input int s);
      case (s)
         0: begin
            @(posedge core_clk) key_req <= 5'h04;
            @(posedge core_clk) key_req <= 5'h00;
         end
         1: begin
            @(posedge core_clk) term_req <= 7'h49;
            @(posedge core_clk) term_req <= 7'h41;
         end
         2: reg_wr(`DRS_REG_CMD, 32'h0000_0004);
         default: begin
            reg_wr(`DRS_REG_CTRL, 32'h0000_0140);
            @(posedge core_clk) auto_reset_req <= 1'b1;
            repeat (4) @(posedge core_clk);
            auto_reset_req <= 1'b0;
            reg_wr(`DRS_REG_CTRL, 32'h0000_0040);
         end
      endcase
   endtask
   task automatic stop_test;
      if (n_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ==========================================
   // tests
   initial begin
      repeat (8) @(negedge core_clk);
      chk("line_status", 32'(`DRS_ST_NOT_READY), 32'(line_status));
      chk("motor_coast", 32'h1, 32'(motor_coast));
      @(posedge core_clk) rstn <= 1'b1;
      reg_rd(`DRS_REG_CTRL, 32'(`DRS_CTRL_RESET));
      reg_rd(8'h3C, 32'h0000_0000);
      @(posedge core_clk) sched_ready <= 1'b0;
      repeat (3) @(negedge core_clk);
      chk("event_code", 32'(`DRS_EVT_SCHED_NOT_READY), 32'(event_code));
      reg_wr(`DRS_REG_CTRL, 32'h0000_0000);
      @(posedge core_clk) {sched_ready, sched_on_missed} <= 2'b11;
      repeat (2) @(negedge core_clk);
      chk("sched_start", 32'h1, 32'(sched_start));
      reg_wr(`DRS_REG_CTRL, 32'h0000_0041);
      @(posedge core_clk) key_req <= 5'h01;
      @(posedge core_clk) term_req <= 7'h40;
      wait_run(1'b1);
      chk("line_control", 32'(`DRS_CTL_HAND), 32'(line_control));
      wait_st(`DRS_ST_RAMPING);
      @(posedge core_clk) at_reference <= 1'b1;
      wait_st(`DRS_ST_RUNNING);
      reg_wr(`DRS_REG_CTRL, 32'h0000_0045);
      @(posedge core_clk) dc_overvolt <= 1'b1;
      wait_st(`DRS_ST_AUTO_RAMP);
      chk("raise_freq", 32'h1, 32'(raise_freq));
      @(posedge core_clk) dc_overvolt <= 1'b0;
      reg_wr(`DRS_REG_CTRL, 32'h0000_0059);
      wait_st(`DRS_ST_BOOST);
      reg_wr(`DRS_REG_CTRL, 32'h0000_0061);
      @(posedge core_clk) demand_low <= 1'b1;
      wait_st(`DRS_ST_SLEEP);
      wait_run(1'b0);
      @(posedge core_clk) demand_low <= 1'b0;
      wait_run(1'b1);
      @(posedge core_clk) key_req <= 5'h03;
      wait_run(1'b0);
      chk("line_control", 32'(`DRS_CTL_OFF), 32'(line_control));
      reg_wr(`DRS_REG_CTRL, 32'h0000_0040);
      @(posedge core_clk) key_req <= 5'h01;
      repeat (8) @(negedge core_clk);
      chk("motor_run", 32'h0, 32'(motor_run));
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk) term_req <= req_tab[i];
         wait_st(st_tab[i]);
         chk("motor_run", 32'h0, 32'(motor_run));
      end
      @(posedge core_clk) key_req <= 5'h00;
      @(posedge core_clk) term_req <= 7'h41;
      wait_run(1'b1);
      @(posedge core_clk) term_req <= 7'h45;
      wait_st(`DRS_ST_STOP);
      reg_wr(`DRS_REG_DELAY, 32'h0000_0010);
      @(posedge core_clk) term_req <= 7'h41;
      wait_st(`DRS_ST_START_DEL);
      wait_run(1'b1);
      reg_wr(`DRS_REG_DELAY, 32'h0000_0000);
      @(posedge core_clk) term_req <= 7'h43;
      wait_st(`DRS_ST_START_FR);
      wait_run(1'b0);
      @(posedge core_clk) term_req <= 7'h41;
      wait_run(1'b1);
      @(posedge core_clk) coast_inhibited_n <= 1'b0;
      wait_st(`DRS_ST_UNREADY);
      wait_run(1'b0);
      @(posedge core_clk) coast_inhibited_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         if (i == 3) reg_wr(`DRS_REG_CTRL, 32'h0000_00C0);
         @(posedge core_clk);
         {off_condition_three, off_condition_two, off_condition_one} <= off_tab[i];
         wait_st(i == 3 ? `DRS_ST_START_INH : `DRS_ST_NOT_READY);
         @(posedge core_clk);
         {off_condition_three, off_condition_two, off_condition_one} <= 3'b111;
      end
      reg_wr(`DRS_REG_CTRL, 32'h0000_0040);
      wait_run(1'b1);
      for (int s = 0; s < 4; s++) begin
         @(posedge core_clk);
         fault_alarm <= 1'b1;
         fault_present <= 1'b1;
         wait_st(`DRS_ST_TRIP);
         chk("warning_flash", 32'h1, 32'(warning_flash));
         @(posedge core_clk) fault_present <= 1'b0;
         repeat (3) @(negedge core_clk);
         chk("warning_flash", 32'h0, 32'(warning_flash));
         chk("alarm_flash", 32'h1, 32'(alarm_flash));
         @(posedge core_clk) fault_alarm <= 1'b0;
         repeat (3) @(negedge core_clk);
         chk("line_status", 32'(`DRS_ST_TRIP), 32'(line_status));
         clear_trip(s);
         wait_run(1'b1);
      end
      @(posedge core_clk);
      fault_alarm <= 1'b1;
      fault_present <= 1'b1;
      fault_lockable <= 1'b1;
      wait_st(`DRS_ST_TRIP_LOCK);
      @(posedge core_clk);
      fault_alarm <= 1'b0;
      fault_present <= 1'b0;
      fault_lockable <= 1'b0;
      clear_trip(2);
      repeat (4) @(negedge core_clk);
      chk("line_status", 32'(`DRS_ST_TRIP_LOCK), 32'(line_status));
      @(posedge core_clk) power_restored <= 1'b1;
      @(posedge core_clk) power_restored <= 1'b0;
      clear_trip(2);
      wait_run(1'b1);
      reg_wr(`DRS_REG_CMD, 32'h0000_0040);
      wait_st(`DRS_ST_ADAPT_DONE);
      repeat (6) @(negedge core_clk);
      chk("motor_run", 32'h0, 32'(motor_run));
      clear_trip(2);
      wait_run(1'b1);
      reg_wr(`DRS_REG_CTRL, 32'h0000_0042);
      repeat (4) @(negedge core_clk);
      chk("line_ref", 32'(`DRS_REF_LOCAL), 32'(line_ref));
      for (int k = 0; k < 2; k++) begin
         r0 = ref_out;
         @(posedge core_clk) key_req <= 5'h08 << k;
         repeat (4) @(posedge core_clk);
         key_req <= 5'h00;
         repeat (4) @(negedge core_clk);
         chk("ref_out moved", 32'h1, 32'(k == 0 ? ref_out > r0 : ref_out < r0));
      end
      reg_wr(`DRS_REG_CTRL, 32'h0000_0040);
      repeat (4) @(negedge core_clk);
      chk("line_ref", 32'(`DRS_REF_REMOTE), 32'(line_ref));
      stop_test();
   end

   // limit well above the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      stop_test();
   end
endmodule // drs_run_status_bench
